// >>> hdl/ifm_defs.vh
/*
  constants for the instruction fetch axi4 read master port.
  assumes inclusion by bare name from the design files of this block.
*/
// Contract
// - the write address valid output is held low forever, so no write ever starts.
// - the write data valid output is held low forever, so no write beat is offered.
// - the write response ready output is held low forever, since no write is issued.
// - only reads are issued, yet all write channel signals exist with their handshakes tied off.
// - every read request carries a burst length of zero, one data beat.
// - every read request carries the size code for eight bytes per beat.
// - every read request carries the incrementing burst type code.
// - every read request carries lock low, never an exclusive access.
// - every read request carries memory type all ones, cacheable and allocating.
// - every read request carries protection code with instruction bit set, unprivileged and secure.
// - every read request carries a quality of service of zero.
// - the core reset clears this port and the core complex but not the debug module.
// - the bus to core clock ratio is chosen by the system through the enable, from 1:1 to 1:8.
`ifndef IFM_DEFS_VH
`define IFM_DEFS_VH

// ----------------------------------------------------------------------------
// fixed read request attributes
// ----------------------------------------------------------------------------
`define IFM_ARLEN     8'h00
`define IFM_ARSIZE    3'h3
`define IFM_ARBURST   2'h1
`define IFM_ARLOCK    1'b0
`define IFM_ARCACHE   4'hf
`define IFM_ARPROT    3'h4
`define IFM_ARQOS     4'h0
`define IFM_ARREGION  4'h0

// ----------------------------------------------------------------------------
// tie-off values of the write channels
// ----------------------------------------------------------------------------
`define IFM_TIE_LOW   1'b0
`define IFM_ADDR_ZERO 32'h0000_0000
`define IFM_DATA_ZERO 64'h0000_0000_0000_0000
`define IFM_STRB_ZERO 8'h00

// ----------------------------------------------------------------------------
// read channel state codes
// ----------------------------------------------------------------------------
`define IFM_ST_IDLE   2'h0
`define IFM_ST_ADDR   2'h1
`define IFM_ST_DATA   2'h2

`endif

// >>> hdl/ifm_read_fsm.v
/*
  read channel sequencer: one outstanding single-beat read, paced by the bus clock enable.
  assumes the slave honours axi4 and returns one beat per read.
*/
`timescale 1ns/1ns
`include "ifm_defs.vh"

module ifm_read_fsm #(
  parameter TAG_W = 3
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             bus_clk_en,
  input  wire             req_valid,
  input  wire [31:0]      req_addr,
  input  wire [TAG_W-1:0] req_tag,
  input  wire             arready,
  input  wire             rvalid,
  input  wire [63:0]      rdata,
  input  wire [1:0]       rresp,
  input  wire [TAG_W-1:0] rid,
  input  wire             rlast,
  output reg              req_ready,
  output reg              arvalid,
  output reg  [31:0]      araddr,
  output reg  [TAG_W-1:0] arid,
  output reg              rready,
  output reg              rsp_valid,
  output reg  [63:0]      rsp_data,
  output reg  [1:0]       rsp_status,
  output reg  [TAG_W-1:0] rsp_tag,
  output reg              rsp_last
);

  reg [1:0] state_reg;

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= `IFM_ST_IDLE;
      req_ready  <= 1'b0;
      arvalid    <= 1'b0;
      araddr     <= `IFM_ADDR_ZERO;
      arid       <= {TAG_W{1'b0}};
      rready     <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_data   <= `IFM_DATA_ZERO;
      rsp_status <= 2'h0;
      rsp_tag    <= {TAG_W{1'b0}};
      rsp_last   <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      if (bus_clk_en) begin
        case (state_reg)
          `IFM_ST_IDLE: begin
            if (req_valid) begin
              arvalid   <= 1'b1;
              araddr    <= req_addr;
              arid      <= req_tag;
              req_ready <= 1'b1;
              state_reg <= `IFM_ST_ADDR;
            end
          end
          `IFM_ST_ADDR: begin
            if (arready) begin
              arvalid   <= 1'b0;
              rready    <= 1'b1;
              state_reg <= `IFM_ST_DATA;
            end
          end
          `IFM_ST_DATA: begin
            if (rvalid) begin
              rready     <= 1'b0;
              rsp_valid  <= 1'b1;
              rsp_data   <= rdata;
              rsp_status <= rresp;
              rsp_tag    <= rid;
              rsp_last   <= rlast;
              state_reg  <= `IFM_ST_IDLE;
            end
          end
          default: begin
            state_reg <= `IFM_ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // ifm_read_fsm

// >>> hdl/ifm_fetch_port.v
/*
  instruction fetch axi4 master port: read-only, write channels tied off.
  assumes core reset is released synchronously and bus_clk_en paces the bus.
*/
`timescale 1ns/1ns
`include "ifm_defs.vh"

module ifm_fetch_port #(
  parameter FETCH_TAG_WIDTH = 3
) (
  input  wire                       clock,
  input  wire                       sys_rst,
  input  wire                       bus_clk_en,
  input  wire                       fetch_req_valid,
  input  wire [31:0]                fetch_req_addr,
  input  wire [FETCH_TAG_WIDTH-1:0] fetch_req_tag,
  output wire                       fetch_req_ready,
  output wire                       fetch_rsp_valid,
  output wire [63:0]                fetch_rsp_data,
  output wire [1:0]                 fetch_rsp_status,
  output wire [FETCH_TAG_WIDTH-1:0] fetch_rsp_tag,
  output wire                       fetch_rsp_last,
  output reg                        axi_awvalid,
  input  wire                       axi_awready,
  output reg  [FETCH_TAG_WIDTH-1:0] axi_awid,
  output reg  [31:0]                axi_awaddr,
  output reg  [7:0]                 axi_awlen,
  output reg  [2:0]                 axi_awsize,
  output reg  [1:0]                 axi_awburst,
  output reg                        axi_awlock,
  output reg  [3:0]                 axi_awcache,
  output reg  [2:0]                 axi_awprot,
  output reg  [3:0]                 axi_awqos,
  output reg  [3:0]                 axi_awregion,
  output reg                        axi_wvalid,
  input  wire                       axi_wready,
  output reg  [63:0]                axi_wdata,
  output reg  [7:0]                 axi_wstrb,
  output reg                        axi_wlast,
  input  wire                       axi_bvalid,
  output reg                        axi_bready,
  input  wire [FETCH_TAG_WIDTH-1:0] axi_bid,
  input  wire [1:0]                 axi_bresp,
  output wire                       axi_arvalid,
  input  wire                       axi_arready,
  output wire [FETCH_TAG_WIDTH-1:0] axi_arid,
  output wire [31:0]                axi_araddr,
  output reg  [7:0]                 axi_arlen,
  output reg  [2:0]                 axi_arsize,
  output reg  [1:0]                 axi_arburst,
  output reg                        axi_arlock,
  output reg  [3:0]                 axi_arcache,
  output reg  [2:0]                 axi_arprot,
  output reg  [3:0]                 axi_arqos,
  output reg  [3:0]                 axi_arregion,
  input  wire                       axi_rvalid,
  output wire                       axi_rready,
  input  wire [FETCH_TAG_WIDTH-1:0] axi_rid,
  input  wire [63:0]                axi_rdata,
  input  wire [1:0]                 axi_rresp,
  input  wire                       axi_rlast
);

  wire rst_n = ~sys_rst;

  // --------------------------------------------------------------------------
  // write channels held disabled
  // --------------------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      axi_awvalid  <= `IFM_TIE_LOW;
      axi_wvalid   <= `IFM_TIE_LOW;
      axi_bready   <= `IFM_TIE_LOW;
      axi_awid     <= {FETCH_TAG_WIDTH{1'b0}};
      axi_awaddr   <= `IFM_ADDR_ZERO;
      axi_awlen    <= `IFM_ARLEN;
      axi_awsize   <= `IFM_ARSIZE;
      axi_awburst  <= `IFM_ARBURST;
      axi_awlock   <= `IFM_ARLOCK;
      axi_awcache  <= `IFM_ARCACHE;
      axi_awprot   <= `IFM_ARPROT;
      axi_awqos    <= `IFM_ARQOS;
      axi_awregion <= `IFM_ARREGION;
      axi_wdata    <= `IFM_DATA_ZERO;
      axi_wstrb    <= `IFM_STRB_ZERO;
      axi_wlast    <= `IFM_TIE_LOW;
    end else begin
      axi_awvalid  <= `IFM_TIE_LOW;
      axi_wvalid   <= `IFM_TIE_LOW;
      axi_bready   <= `IFM_TIE_LOW;
      axi_awid     <= {FETCH_TAG_WIDTH{1'b0}};
      axi_awaddr   <= `IFM_ADDR_ZERO;
      axi_awlen    <= `IFM_ARLEN;
      axi_awsize   <= `IFM_ARSIZE;
      axi_awburst  <= `IFM_ARBURST;
      axi_awlock   <= `IFM_ARLOCK;
      axi_awcache  <= `IFM_ARCACHE;
      axi_awprot   <= `IFM_ARPROT;
      axi_awqos    <= `IFM_ARQOS;
      axi_awregion <= `IFM_ARREGION;
      axi_wdata    <= `IFM_DATA_ZERO;
      axi_wstrb    <= `IFM_STRB_ZERO;
      axi_wlast    <= `IFM_TIE_LOW;
    end
  end

  // --------------------------------------------------------------------------
  // fixed read attributes
  // --------------------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      axi_arlen    <= `IFM_ARLEN;
      axi_arsize   <= `IFM_ARSIZE;
      axi_arburst  <= `IFM_ARBURST;
      axi_arlock   <= `IFM_ARLOCK;
      axi_arcache  <= `IFM_ARCACHE;
      axi_arprot   <= `IFM_ARPROT;
      axi_arqos    <= `IFM_ARQOS;
      axi_arregion <= `IFM_ARREGION;
    end else begin
      axi_arlen    <= `IFM_ARLEN;
      axi_arsize   <= `IFM_ARSIZE;
      axi_arburst  <= `IFM_ARBURST;
      axi_arlock   <= `IFM_ARLOCK;
      axi_arcache  <= `IFM_ARCACHE;
      axi_arprot   <= `IFM_ARPROT;
      axi_arqos    <= `IFM_ARQOS;
      axi_arregion <= `IFM_ARREGION;
    end
  end

  // --------------------------------------------------------------------------
  // read sequencer
  // --------------------------------------------------------------------------
  ifm_read_fsm #(
    .TAG_W (FETCH_TAG_WIDTH)
  ) u_read (
    .clock      (clock),
    .rst_n      (rst_n),
    .bus_clk_en (bus_clk_en),
    .req_valid  (fetch_req_valid),
    .req_addr   (fetch_req_addr),
    .req_tag    (fetch_req_tag),
    .arready    (axi_arready),
    .rvalid     (axi_rvalid),
    .rdata      (axi_rdata),
    .rresp      (axi_rresp),
    .rid        (axi_rid),
    .rlast      (axi_rlast),
    .req_ready  (fetch_req_ready),
    .arvalid    (axi_arvalid),
    .araddr     (axi_araddr),
    .arid       (axi_arid),
    .rready     (axi_rready),
    .rsp_valid  (fetch_rsp_valid),
    .rsp_data   (fetch_rsp_data),
    .rsp_status (fetch_rsp_status),
    .rsp_tag    (fetch_rsp_tag),
    .rsp_last   (fetch_rsp_last)
  );

endmodule // ifm_fetch_port

// >>> test/ifm_monitor.sv
/* assertion checker for the fetch port.
   assumes a bind onto ifm_fetch_port. */
`timescale 1ns/1ns
module ifm_monitor #(parameter FETCH_TAG_WIDTH = 3) (
  input wire                       clock, sys_rst, bus_clk_en, fetch_req_ready, fetch_rsp_valid,
  input wire [31:0]                fetch_req_addr, axi_araddr,
  input wire [63:0]                fetch_rsp_data, axi_rdata,
  input wire                       axi_awvalid, axi_wvalid, axi_bready, axi_arvalid, axi_arready,
  input wire                       axi_rvalid, axi_rready, axi_arlock,
  input wire [FETCH_TAG_WIDTH-1:0] axi_arid,
  input wire [7:0]                 axi_arlen,
  input wire [3:0]                 axi_arcache, axi_arqos,
  input wire [2:0]                 axi_arsize, axi_arprot,
  input wire [1:0]                 axi_arburst
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_no_awvalid: assert property (!axi_awvalid) else $error("write address valid raised");
  a_no_wvalid: assert property (!axi_wvalid) else $error("write data valid raised");
  a_no_bready: assert property (!axi_bready) else $error("write response ready raised");
  a_len_size: assert property (axi_arvalid |-> axi_arlen == 8'h00 && axi_arsize == 3'h3)
    else $error("read length or size wrong");
  a_burst_lock: assert property (axi_arvalid |-> axi_arburst == 2'h1 && !axi_arlock)
    else $error("read burst or lock wrong");
  a_cache_prot: assert property (axi_arvalid |-> {axi_arcache, axi_arprot, axi_arqos} == 11'h7c0)
    else $error("read cache, prot or qos wrong");
  a_ar_hold: assert property (axi_arvalid && !(bus_clk_en && axi_arready) |=>
    axi_arvalid && $stable(axi_araddr) && $stable(axi_arid)) else $error("read address dropped early");
  a_ar_to_r: assert property (axi_arvalid && axi_arready && bus_clk_en |=> !axi_arvalid && axi_rready)
    else $error("read address accept not followed by read ready");
  a_r_to_rsp: assert property (axi_rready && axi_rvalid && bus_clk_en |=>
    fetch_rsp_valid && !axi_rready && fetch_rsp_data == $past(axi_rdata)) else $error("read beat not forwarded");
  a_req_take: assert property (fetch_req_ready |-> axi_arvalid && axi_araddr == $past(fetch_req_addr))
    else $error("request taken without read address");
endmodule // ifm_monitor

// >>> test/ifm_axi_slave.sv
/* read-only axi4 slave standing in for the interconnect.
   assumes it shares clock, reset and bus enable with the port. */
`timescale 1ns/1ns
module ifm_axi_slave (
  input wire        clock, sys_rst, bus_clk_en, stall, axi_arvalid, axi_rready,
  input wire [31:0] axi_araddr,
  input wire [2:0]  axi_arid,
  output reg        axi_arready, axi_rvalid, axi_rlast,
  output reg [2:0]  axi_rid,
  output reg [1:0]  axi_rresp,
  output reg [63:0] axi_rdata
);
  reg        busy_reg;
  reg [31:0] addr_reg;
  reg [2:0]  id_reg;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {axi_arready, axi_rvalid, axi_rlast, axi_rid, axi_rresp, axi_rdata, busy_reg} <= 0;
      {addr_reg, id_reg} <= 0;
    end else if (bus_clk_en) begin
      axi_arready <= !busy_reg && !(axi_arvalid && axi_arready) && (!stall || 1'($urandom));
      if (axi_arvalid && axi_arready) begin
        busy_reg <= 1'b1;
        {addr_reg, id_reg} <= {axi_araddr, axi_arid};
      end
      if (axi_rvalid && axi_rready) begin
        {axi_rvalid, axi_rlast, busy_reg} <= 0;
        axi_rdata <= ~axi_rdata;
      end else if (busy_reg && !axi_rvalid && (!stall || 1'($urandom))) begin
        {axi_rvalid, axi_rlast} <= 2'h3;
        {axi_rid, axi_rresp, axi_rdata} <= {id_reg, addr_reg[4:3], addr_reg, ~addr_reg};
      end
    end
  end
endmodule // ifm_axi_slave

// >>> test/tb_top.sv
/* testbench for the fetch port with a queue of expected responses.
   assumes ifm_axi_slave as the far side. */
`timescale 1ns/1ns
module tb_top;
  logic        clock, sys_rst, bus_clk_en, fetch_req_valid, stall, fetch_req_ready, fetch_rsp_valid, fetch_rsp_last;
  logic        axi_awvalid, axi_awlock, axi_wvalid, axi_wlast, axi_bready, axi_arvalid, axi_arlock, axi_rready;
  logic        axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid, axi_rlast;
  logic [1:0]  fetch_rsp_status, axi_awburst, axi_arburst, axi_bresp, axi_rresp;
  logic [2:0]  fetch_req_tag, fetch_rsp_tag, axi_awid, axi_bid, axi_arid, axi_rid, axi_awsize, axi_awprot;
  logic [2:0]  axi_arsize, axi_arprot;
  logic [3:0]  axi_awcache, axi_awqos, axi_awregion, axi_arcache, axi_arqos, axi_arregion;
  logic [7:0]  axi_awlen, axi_wstrb, axi_arlen;
  logic [31:0] fetch_req_addr, axi_awaddr, axi_araddr;
  logic [63:0] fetch_rsp_data, axi_wdata, axi_rdata;
  logic [69:0] exp_q[$];
  int          n_mismatch, n_tests, ratio, en_cnt, r, i;
  ifm_fetch_port DUT (.*);
  ifm_axi_slave u_slv (.clock, .sys_rst, .bus_clk_en, .stall, .axi_arvalid, .axi_rready, .axi_araddr,
    .axi_arid, .axi_arready, .axi_rvalid, .axi_rlast, .axi_rid, .axi_rresp, .axi_rdata);
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  task automatic check(input string name, input logic [69:0] seen, input logic [69:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task fetch(input logic [31:0] a, input logic [2:0] t);
    @(posedge clock);
    {fetch_req_valid, fetch_req_addr, fetch_req_tag} <= {1'b1, a, t};
    exp_q.push_back({1'b1, t, a[4:3], a, ~a});
    for (i = 0; i < 1000 && fetch_req_ready !== 1'b1; i++) @(negedge clock);
    if (i == 1000) begin
      n_mismatch++;
      end_of_test;
    end
    @(posedge clock) fetch_req_valid <= 1'b0;
  endtask
  task drain;
    for (i = 0; i < 1000 && exp_q.size() > 0; i++) @(negedge clock);
    if (i == 1000) begin
      n_mismatch++;
      end_of_test;
    end
  endtask
  always @(posedge clock) begin
    en_cnt <= (en_cnt + 1 >= ratio) ? 0 : en_cnt + 1;
    bus_clk_en <= (en_cnt == 0);
    {axi_awready, axi_wready, axi_bvalid, axi_bid, axi_bresp} <= 8'($urandom);
  end
  always @(negedge clock) begin
    if (fetch_rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check("spurious response", 1, 0);
      else check("response", {fetch_rsp_last, fetch_rsp_tag, fetch_rsp_status, fetch_rsp_data}, exp_q.pop_front());
    end
  end
  initial begin
    {fetch_req_valid, fetch_req_addr, fetch_req_tag, stall} = 0;
    {n_mismatch, n_tests, sys_rst, ratio} = {32'd0, 32'd0, 1'b1, 32'd1};
    void'($urandom(51));
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check("write handshakes", {axi_awvalid, axi_wvalid, axi_bready}, 0);
    check("read attributes", {axi_arlen, axi_arsize, axi_arburst, axi_arlock, axi_arcache, axi_arprot, axi_arqos},
      {8'h00, 3'h3, 2'h1, 1'b0, 4'hf, 3'h4, 4'h0});
    check("write address", {axi_awid, axi_awaddr, axi_awlen, axi_awsize, axi_awburst, axi_awlock},
      {3'h0, 32'h0000_0000, 8'h00, 3'h3, 2'h1, 1'b0});
    check("write data", {axi_wdata, axi_wlast}, 0);
    check("write tail", {axi_awcache, axi_awprot, axi_awqos, axi_awregion, axi_wstrb, axi_arregion},
      {4'hf, 3'h4, 4'h0, 4'h0, 8'h00, 4'h0});
    for (r = 1; r <= 8; r++) begin
      @(posedge clock) {ratio, stall} <= {r, r[0]};
      repeat (3) fetch(32'($urandom) & 32'hffff_fff8, 3'($urandom));
      drain;
    end
    fetch(32'h0000_1000, 3'h5);
    @(posedge clock) sys_rst <= 1'b1;
    @(negedge clock) exp_q.delete();
    check("reset outputs", {axi_arvalid, axi_rready, fetch_req_ready, fetch_rsp_valid}, 0);
    @(posedge clock) sys_rst <= 1'b0;
    fetch(32'h0000_2008, 3'h2);
    drain;
    end_of_test;
  end
endmodule // tb_top
bind ifm_fetch_port ifm_monitor #(.FETCH_TAG_WIDTH(FETCH_TAG_WIDTH)) u_mon (.clock, .sys_rst, .bus_clk_en,
  .fetch_req_ready, .fetch_rsp_valid, .fetch_req_addr, .axi_araddr, .fetch_rsp_data, .axi_rdata, .axi_awvalid,
  .axi_wvalid, .axi_bready, .axi_arvalid, .axi_arready, .axi_rvalid, .axi_rready, .axi_arlock, .axi_arid,
  .axi_arlen, .axi_arcache, .axi_arqos, .axi_arsize, .axi_arprot, .axi_arburst);
